// [shared/im_pkg.sv]
// constants, register map and carrier types of the two-wire master block
// assumes a 32-bit ahb-lite register bus and a separate serial engine clock
package im_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_TIMING = 8'h14;
    localparam logic [7:0] OFS_PEER = 8'h18;
    localparam logic [7:0] OFS_PAYLOAD = 8'h1c;
    localparam logic [7:0] OFS_TARGET = 8'h20;
    localparam logic [7:0] OFS_CONTROL = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    // field positions
    localparam int TM_GAP_MSB = 31;
    localparam int TM_GAP_LSB = 16;
    localparam int TM_FREE_MSB = 15;
    localparam int TM_FREE_LSB = 0;
    localparam int PEER_DIR_BIT = 0;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int STAT_ACK_BIT = 0;
    localparam int HTRANS_ACTIVE_BIT = 1;
    // reset values
    localparam logic [31:0] WORD_RST = 32'h0;
    localparam logic [7:0] BYTE_RST = 8'h0;
    localparam logic [15:0] CNT_RST = 16'h0;
    // ninth bit of a byte slot carries the acknowledge
    localparam logic [3:0] ACK_BIT_IDX = 4'h8;
    localparam logic [1:0] STEP_ADDR = 2'h0;
    localparam logic [1:0] STEP_TARGET = 2'h1;
    localparam logic [1:0] STEP_DATA = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_START = 7'h02,
        ST_XFER = 7'h04,
        ST_GAP = 7'h08,
        ST_HOLD = 7'h10,
        ST_STOP = 7'h20,
        ST_FREE = 7'h40
    } im_state_type;

    typedef struct packed {
        logic [15:0] gap;
        logic [15:0] free;
        logic [7:0] target;
    } im_cfg_type;

    // commands toward the serial engine, each a toggle
    typedef struct packed {
        logic start;
        logic stop;
        logic more;
    } im_cmd_type;

    // status from the serial engine
    typedef struct packed {
        logic ack_tgl;
        logic nack;
        logic busy;
    } im_lstat_type;
endpackage : im_pkg

// [hw/im_sync3.sv]
// three-stage synchroniser with agreement filter, one lane per bit
// assumes d comes from another clock domain or a pin
`timescale 1ns/1ns
`default_nettype none
module im_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_lane
            logic s1_q;
            logic s2_q;
            logic s3_q;
            // s1 feeds only s2; a change counts once s2 and s3 agree
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s1_q <= 1'h0;
                    s2_q <= 1'h0;
                    s3_q <= 1'h0;
                    q[gi] <= 1'h0;
                end
                else
                begin
                    s1_q <= d[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        q[gi] <= s3_q;
                end
            end
        end
    endgenerate
endmodule : im_sync3
`default_nettype wire

// [hw/im_i2c_master.sv]
// two-wire bus master: byte gap and bus-free timing, peer select, payload byte
// assumes ahb-lite on clk and a free-running serial engine clock ser_clk
`timescale 1ns/1ns
`default_nettype none
module im_i2c_master #(
    parameter logic [15:0] HALF_CYCLES = 16'h0008
) (
    // system clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial link
    input wire logic ser_clk,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    // ---------------- system domain ----------------
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [31:0] timing_q;
    logic [7:0] peer_q;
    logic [7:0] target_q;
    logic [7:0] payload_q;
    logic [7:0] rx_q;
    logic active_q;
    logic stopped_q;
    logic ack_seen_q;
    logic ack_prev_q;
    im_pkg::im_cmd_type cmd_q;
    im_pkg::im_lstat_type lst_l;
    im_pkg::im_lstat_type lst_s;
    logic [7:0] lrx_q;

    wire addr_ok = hsel && htrans[im_pkg::HTRANS_ACTIVE_BIT] && hready;
    wire [7:0] a_ofs = haddr[7:0];
    wire rd_now = addr_ok && !hwrite;
    wire rd_payload = rd_now && (a_ofs == im_pkg::OFS_PAYLOAD);
    wire wr_timing = dp_wr_q && (dp_addr_q == im_pkg::OFS_TIMING);
    wire wr_peer = dp_wr_q && (dp_addr_q == im_pkg::OFS_PEER);
    wire wr_payload = dp_wr_q && (dp_addr_q == im_pkg::OFS_PAYLOAD);
    wire wr_target = dp_wr_q && (dp_addr_q == im_pkg::OFS_TARGET);
    wire wr_ctrl = dp_wr_q && (dp_addr_q == im_pkg::OFS_CONTROL);
    wire wr_status = dp_wr_q && (dp_addr_q == im_pkg::OFS_STATUS);
    wire go_start = wr_ctrl && hwdata[im_pkg::CTRL_START_BIT];
    wire go_stop = wr_ctrl && hwdata[im_pkg::CTRL_STOP_BIT];
    wire open_txn = active_q && !stopped_q;
    wire dir_rd = peer_q[im_pkg::PEER_DIR_BIT];
    wire more_rd = rd_payload && open_txn && dir_rd;
    // next byte of a write is sent when software supplies it
    wire more_wr = wr_payload && open_txn && !dir_rd;
    wire ack_ev = lst_s.ack_tgl ^ ack_prev_q;
    wire [31:0] status_w = {28'h0, stopped_q, lst_s.busy, lst_s.nack, ack_seen_q};
    wire [31:0] rd_val = (a_ofs == im_pkg::OFS_TIMING) ? timing_q :
        (a_ofs == im_pkg::OFS_PEER) ? {24'h0, peer_q} :
        (a_ofs == im_pkg::OFS_PAYLOAD) ? {24'h0, dir_rd ? rx_q : payload_q} :
        (a_ofs == im_pkg::OFS_TARGET) ? {24'h0, target_q} :
        (a_ofs == im_pkg::OFS_STATUS) ? status_w : im_pkg::WORD_RST;

    // zero-wait slave: every answer is okay, unmapped reads give zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dp_wr_q <= 1'h0;
            dp_addr_q <= im_pkg::BYTE_RST;
            hrdata <= im_pkg::WORD_RST;
            hreadyout <= 1'h0;
            hresp <= 1'h0;
        end
        else
        begin
            dp_wr_q <= addr_ok && hwrite;
            dp_addr_q <= a_ofs;
            hrdata <= rd_now ? rd_val : im_pkg::WORD_RST;
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timing_q <= im_pkg::WORD_RST;
            peer_q <= im_pkg::BYTE_RST;
            target_q <= im_pkg::BYTE_RST;
            payload_q <= im_pkg::BYTE_RST;
        end
        else
        begin
            if (wr_timing)
                timing_q <= hwdata;
            if (wr_peer)
                peer_q <= hwdata[7:0];
            if (wr_target)
                target_q <= hwdata[7:0];
            if (wr_payload)
                payload_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_q <= '0;
            active_q <= 1'h0;
            stopped_q <= 1'h0;
            ack_prev_q <= 1'h0;
            ack_seen_q <= 1'h0;
            rx_q <= im_pkg::BYTE_RST;
        end
        else
        begin
            cmd_q.start <= cmd_q.start ^ go_start;
            cmd_q.stop <= cmd_q.stop ^ go_stop;
            cmd_q.more <= cmd_q.more ^ (more_rd ^ more_wr);
            if (go_start)
                active_q <= 1'h1;
            if (go_stop)
                stopped_q <= 1'h1;
            else if (go_start)
                stopped_q <= 1'h0;
            ack_prev_q <= lst_s.ack_tgl;
            if (ack_ev)
                rx_q <= lrx_q;
            // set wins over a write-one clear
            if (ack_ev)
                ack_seen_q <= 1'h1;
            else if (wr_status && hwdata[im_pkg::STAT_ACK_BIT])
                ack_seen_q <= 1'h0;
        end
    end

    // ---------------- serial domain ----------------
    logic [1:0] lrst_q;
    wire lrst_n = lrst_q[1];
    im_pkg::im_cmd_type cmd_s;
    im_pkg::im_cmd_type cmd_prev_q;
    logic [1:0] pin_s;
    im_pkg::im_state_type st_q;
    im_pkg::im_cfg_type cfg_q;
    logic [15:0] cnt_q;
    logic [3:0] bit_q;
    logic ph_q;
    logic [7:0] tx_q;
    logic [1:0] step_q;
    logic rdir_q;
    logic stop_pend_q;
    logic more_pend_q;

    // reset leaves the serial domain only on its own clock edge
    always_ff @(posedge ser_clk or negedge arst_n)
    begin
        if (!arst_n)
            lrst_q <= 2'h0;
        else
            lrst_q <= {lrst_q[0], 1'h1};
    end

    im_sync3 #(.W(3)) u_cmd_sync (.clk(ser_clk), .arst_n(lrst_n), .d(cmd_q), .q(cmd_s));
    im_sync3 #(.W(2)) u_pin_sync (.clk(ser_clk), .arst_n(lrst_n), .d({scl_i, sda_i}),
        .q(pin_s));
    im_sync3 #(.W(3)) u_stat_sync (.clk(clk), .arst_n(arst_n), .d(lst_l), .q(lst_s));

    wire scl_f = pin_s[1];
    wire sda_f = pin_s[0];
    wire [2:0] cmd_ev = cmd_s ^ cmd_prev_q;
    wire start_ev = cmd_ev[2];
    wire stop_ev = cmd_ev[1];
    wire more_ev = cmd_ev[0];
    wire [15:0] cnt_inc = cnt_q + 16'h1;
    wire half_done = cnt_q == HALF_CYCLES;
    wire last_bit = bit_q == im_pkg::ACK_BIT_IDX;
    wire rx_cur = rdir_q && (step_q != im_pkg::STEP_ADDR);
    wire bit_end = ph_q && scl_f && half_done;
    wire nack_now = !rx_cur && sda_f;
    wire auto_next = nack_now || (step_q == im_pkg::STEP_ADDR) ||
        ((step_q == im_pkg::STEP_TARGET) && !rdir_q);
    wire [1:0] step_nx = (step_q == im_pkg::STEP_DATA) ? step_q : step_q + 2'h1;
    // master acknowledges received bytes, releases for the peer's
    wire sda_pull = last_bit ? rx_cur : (!rx_cur && !tx_q[7]);
    // config words are stable while software waits for the start to land
    wire [15:0] gap_in = timing_q[im_pkg::TM_GAP_MSB:im_pkg::TM_GAP_LSB];
    wire [15:0] free_in = timing_q[im_pkg::TM_FREE_MSB:im_pkg::TM_FREE_LSB];

    always_ff @(posedge ser_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            scl_o <= 1'h0;
            sda_o <= 1'h0;
            cmd_prev_q <= '0;
        end
        else
        begin
            scl_o <= 1'h0;
            sda_o <= 1'h0;
            cmd_prev_q <= cmd_s;
        end
    end

    always_ff @(posedge ser_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            st_q <= im_pkg::ST_IDLE;
            cfg_q <= '0;
            cnt_q <= im_pkg::CNT_RST;
            bit_q <= 4'h0;
            ph_q <= 1'h0;
            tx_q <= im_pkg::BYTE_RST;
            lrx_q <= im_pkg::BYTE_RST;
            step_q <= im_pkg::STEP_ADDR;
            rdir_q <= 1'h0;
            stop_pend_q <= 1'h0;
            more_pend_q <= 1'h0;
            lst_l <= '0;
            scl_oe <= 1'h0;
            sda_oe <= 1'h0;
        end
        else
        begin
            if (stop_ev)
                stop_pend_q <= 1'h1;
            if (more_ev)
                more_pend_q <= 1'h1;
            case (st_q)
                im_pkg::ST_IDLE:
                begin
                    scl_oe <= 1'h0;
                    sda_oe <= 1'h0;
                    cnt_q <= im_pkg::CNT_RST;
                    if (start_ev)
                    begin
                        cfg_q <= '{gap: gap_in, free: free_in, target: target_q};
                        tx_q <= peer_q;
                        rdir_q <= peer_q[im_pkg::PEER_DIR_BIT];
                        step_q <= im_pkg::STEP_ADDR;
                        stop_pend_q <= 1'h0;
                        more_pend_q <= 1'h0;
                        sda_oe <= 1'h1;
                        lst_l.busy <= 1'h1;
                        st_q <= im_pkg::ST_START;
                    end
                end
                im_pkg::ST_START:
                begin
                    cnt_q <= cnt_inc;
                    if (half_done)
                    begin
                        scl_oe <= 1'h1;
                        cnt_q <= im_pkg::CNT_RST;
                        bit_q <= 4'h0;
                        ph_q <= 1'h0;
                        st_q <= im_pkg::ST_XFER;
                    end
                end
                im_pkg::ST_XFER:
                begin
                    if (!ph_q)
                    begin
                        sda_oe <= sda_pull;
                        cnt_q <= cnt_inc;
                        if (half_done)
                        begin
                            scl_oe <= 1'h0;
                            ph_q <= 1'h1;
                            cnt_q <= im_pkg::CNT_RST;
                        end
                    end
                    else if (!scl_f)
                        cnt_q <= im_pkg::CNT_RST;
                    else if (!half_done)
                        cnt_q <= cnt_inc;
                    else
                    begin
                        scl_oe <= 1'h1;
                        ph_q <= 1'h0;
                        cnt_q <= im_pkg::CNT_RST;
                        bit_q <= bit_q + 4'h1;
                        if (!last_bit)
                        begin
                            lrx_q <= {lrx_q[6:0], sda_f};
                            tx_q <= {tx_q[6:0], 1'h0};
                        end
                        else
                        begin
                            bit_q <= 4'h0;
                            lst_l.ack_tgl <= ~lst_l.ack_tgl;
                            lst_l.nack <= nack_now;
                            step_q <= step_nx;
                            tx_q <= (step_q == im_pkg::STEP_ADDR) ? cfg_q.target : payload_q;
                            if (nack_now)
                                stop_pend_q <= 1'h1;
                            st_q <= auto_next ? im_pkg::ST_GAP : im_pkg::ST_HOLD;
                        end
                    end
                end
                im_pkg::ST_GAP:
                begin
                    cnt_q <= cnt_inc;
                    if (cnt_q == cfg_q.gap)
                    begin
                        cnt_q <= im_pkg::CNT_RST;
                        ph_q <= 1'h0;
                        bit_q <= 4'h0;
                        sda_oe <= stop_pend_q;
                        st_q <= stop_pend_q ? im_pkg::ST_STOP : im_pkg::ST_XFER;
                    end
                end
                im_pkg::ST_HOLD:
                begin
                    cnt_q <= im_pkg::CNT_RST;
                    // gap before next byte or stop
                    if (stop_pend_q || stop_ev)
                    begin
                        stop_pend_q <= 1'h1;
                        st_q <= im_pkg::ST_GAP;
                    end
                    else if (more_pend_q || more_ev)
                    begin
                        more_pend_q <= 1'h0;
                        tx_q <= payload_q;
                        st_q <= im_pkg::ST_GAP;
                    end
                end
                im_pkg::ST_STOP:
                begin
                    if (!ph_q)
                    begin
                        cnt_q <= cnt_inc;
                        if (half_done)
                        begin
                            scl_oe <= 1'h0;
                            ph_q <= 1'h1;
                            cnt_q <= im_pkg::CNT_RST;
                        end
                    end
                    else if (!scl_f)
                        cnt_q <= im_pkg::CNT_RST;
                    else if (!half_done)
                        cnt_q <= cnt_inc;
                    else
                    begin
                        sda_oe <= 1'h0;
                        cnt_q <= im_pkg::CNT_RST;
                        st_q <= im_pkg::ST_FREE;
                    end
                end
                im_pkg::ST_FREE:
                begin
                    cnt_q <= cnt_inc;
                    if (cnt_q == cfg_q.free)
                    begin
                        lst_l.busy <= 1'h0;
                        stop_pend_q <= 1'h0;
                        st_q <= im_pkg::ST_IDLE;
                    end
                end
                default:
                    st_q <= im_pkg::ST_IDLE;
            endcase
        end
    end

    // ---------------- checks ----------------
    sequence s_start_taken;
        st_q == im_pkg::ST_IDLE && start_ev;
    endsequence
    sequence s_hold_stop;
        st_q == im_pkg::ST_HOLD && (stop_pend_q || stop_ev);
    endsequence
    property p_gap_wait;
        @(posedge ser_clk) disable iff (!lrst_n)
        (st_q == im_pkg::ST_GAP && cnt_q != cfg_q.gap) |=> st_q == im_pkg::ST_GAP;
    endproperty
    a_gap_wait: assert property (p_gap_wait) else $error("gap ended early");
    property p_stop_gap;
        @(posedge ser_clk) disable iff (!lrst_n)
        s_hold_stop |=> (st_q == im_pkg::ST_GAP && stop_pend_q && cnt_q == im_pkg::CNT_RST);
    endproperty
    a_stop_gap: assert property (p_stop_gap) else $error("stop without gap");
    property p_stall;
        @(posedge ser_clk) disable iff (!lrst_n)
        (st_q == im_pkg::ST_XFER && ph_q && !scl_f) |=> (!scl_oe && $stable(bit_q) && cnt_q == 0);
    endproperty
    a_stall: assert property (p_stall) else $error("moved during stall");
    property p_free;
        @(posedge ser_clk) disable iff (!lrst_n)
        (st_q == im_pkg::ST_FREE && cnt_q != cfg_q.free) |=>
            (st_q == im_pkg::ST_FREE && !scl_oe && !sda_oe);
    endproperty
    a_free: assert property (p_free) else $error("bus-free cut short");
    property p_addr;
        @(posedge ser_clk) disable iff (!lrst_n)
        s_start_taken |=> (tx_q == peer_q && rdir_q == peer_q[0]) ##1 st_q == im_pkg::ST_START;
    endproperty
    a_addr: assert property (p_addr) else $error("address byte wrong");
    property p_third;
        @(posedge ser_clk) disable iff (!lrst_n)
        (st_q == im_pkg::ST_XFER && bit_end && last_bit && !nack_now &&
            step_q == im_pkg::STEP_TARGET && !rdir_q) |=> tx_q == payload_q;
    endproperty
    a_third: assert property (p_third) else $error("third byte not payload");
    property p_ack;
        @(posedge ser_clk) disable iff (!lrst_n)
        (st_q == im_pkg::ST_XFER && bit_end && last_bit) |=> lst_l.ack_tgl != $past(lst_l.ack_tgl);
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge event");
    property p_more_rd;
        @(posedge clk) disable iff (!arst_n)
        (more_rd && !more_wr) |=> cmd_q.more != $past(cmd_q.more);
    endproperty
    a_more_rd: assert property (p_more_rd) else $error("read did not fetch");
    property p_no_more;
        @(posedge clk) disable iff (!arst_n)
        (rd_payload && stopped_q) |=> $stable(cmd_q.more);
    endproperty
    a_no_more: assert property (p_no_more) else $error("read after stop moved bus");
    property p_stop_cmd;
        @(posedge clk) disable iff (!arst_n)
        go_stop |=> (stopped_q && cmd_q.stop != $past(cmd_q.stop));
    endproperty
    a_stop_cmd: assert property (p_stop_cmd) else $error("stop not passed");
endmodule : im_i2c_master
`default_nettype wire

// [test/im_peer_model.sv]
// peripheral model on the two-wire bus: acks received bytes, serves read bytes
// assumes the bench resolves both wires from all pull-down enables with pull-ups
`timescale 1ns/1ns
`default_nettype none
module im_peer_model (
    // resolved wires and test control
    input wire logic scl,
    input wire logic sda,
    input wire logic stall_en,
    // pull-down enables, high pulls the wire low
    output logic scl_oe,
    output logic sda_oe
);
    logic [7:0] got [0:7];
    logic [7:0] send [0:2] = '{8'h96, 8'hb4, 8'hff};
    logic [7:0] rx;
    logic rd;
    logic stp;
    int n_got = 0;
    int n_sent = 0;
    realtime t_fall = 0;
    realtime t_low = 0;
    realtime t_stop = 0;
    realtime free_gap = 0;
    always @(negedge scl) t_fall = $realtime;
    always @(posedge scl) if ($realtime - t_fall > t_low) t_low = $realtime - t_fall;
    always @(posedge sda) if (scl) t_stop = $realtime;
    always @(negedge sda) if (scl) free_gap = $realtime - t_stop;
    // data moves 3 ns after the falling clock so the master never sees a false edge
    task automatic slot(input logic [7:0] tx, input logic drv);
        for (int i = 7; i >= 0; i--)
        begin
            #3 sda_oe = drv & !tx[i];
            @(posedge scl);
            rx[i] = sda;
            @(negedge scl or posedge sda);
            if (scl)
            begin
                stp = 1;
                sda_oe = 0;
                return;
            end
        end
        #3 sda_oe = !drv;
        if (stall_en)
        begin
            scl_oe = 1;
            #100 scl_oe = 0;
        end
        // a released stall may raise the clock in this very step, so test the level
        wait (scl === 1'b1);
        @(negedge scl);
    endtask : slot
    initial
    begin
        scl_oe = 0;
        sda_oe = 0;
        forever
        begin
            @(negedge sda iff scl === 1'b1);
            stp = 0;
            @(negedge scl);
            slot(8'hff, 1'b0);
            rd = rx[0];
            got[n_got] = rx;
            n_got++;
            while (!stp)
            begin
                slot(rd ? send[n_sent] : 8'hff, rd);
                if (!stp && rd)
                    n_sent++;
                if (!stp && !rd)
                begin
                    got[n_got] = rx;
                    n_got++;
                end
            end
        end
    end
endmodule : im_peer_model
`default_nettype wire

// [test/im_i2c_master_test.sv]
// bench: register access, a write and a read transfer, byte gap and bus-free time
// assumes the design is the only ahb-lite slave and its pins are open drain
`timescale 1ns/1ns
`default_nettype none
module im_i2c_master_test;
    logic clk, ser_clk, arst_n, hsel, hwrite, hreadyout, hresp, stall_en;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic scl_oe, sda_oe, scl_o, sda_o, p_scl_oe, p_sda_oe;
    wire scl = !(scl_oe | p_scl_oe);
    wire sda = !(sda_oe | p_sda_oe);
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] regs [0:3] = '{8'h14, 8'h18, 8'h1c, 8'h3c};
    im_i2c_master #(.HALF_CYCLES(16'h0002)) u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ser_clk(ser_clk), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe));
    im_peer_model u_peer (.scl(scl), .sda(sda), .stall_en(stall_en), .scl_oe(p_scl_oe),
        .sda_oe(p_sda_oe));
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        ser_clk = 0;
        #3;
        forever #6 ser_clk = ~ser_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_min(input string what, input realtime lo, input realtime got);
        comparisons++;
        if (!(got >= lo))
        begin
            fail_count++;
            $display("ERROR %s expected at least %0.1f seen %0.1f", what, lo, got);
        end
    endtask : chk_min
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask : bus
    task automatic wait_idle();
        do bus(0, im_pkg::OFS_STATUS, 0); while (rdat[2] !== 1'b0);
    endtask : wait_idle
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, stall_en} = '0;
        hsize = 3'h2;
        arst_n = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        foreach (regs[i])
        begin
            bus(0, regs[i], 0);
            chk("reset value", 0, rdat);
        end
        bus(1, im_pkg::OFS_TIMING, 32'h0003_0187);
        bus(0, im_pkg::OFS_TIMING, 0);
        chk("timing", 32'h0003_0187, rdat);
        bus(1, im_pkg::OFS_PEER, 32'h54);
        bus(1, im_pkg::OFS_TARGET, 32'h5a);
        bus(1, im_pkg::OFS_PAYLOAD, 32'hc3);
        stall_en <= 1'b1;
        bus(1, im_pkg::OFS_CONTROL, 32'h1);
        while (u_peer.n_got < 3) @(posedge clk);
        chk("address byte", 32'h54, 32'(u_peer.got[0]));
        chk("target byte", 32'h5a, 32'(u_peer.got[1]));
        chk("payload byte", 32'hc3, 32'(u_peer.got[2]));
        bus(1, im_pkg::OFS_CONTROL, 32'h2);
        wait_idle();
        chk("stop seen", 1, 32'(u_peer.stp));
        chk("bytes taken", 3, u_peer.n_got);
        chk("status after stop", 32'h9, rdat);
        chk("drive levels", 0, 32'({hresp, scl_o, sda_o}));
        $display("write test done");
        stall_en <= 1'b0;
        bus(1, im_pkg::OFS_TIMING, 32'h0028_0187);
        bus(1, im_pkg::OFS_PEER, 32'h55);
        u_peer.t_low = 0;
        bus(1, im_pkg::OFS_CONTROL, 32'h1);
        while (u_peer.n_sent < 1) @(posedge clk);
        chk_min("bus free time", 392 * 12.0, u_peer.free_gap);
        chk("read address byte", 32'h55, 32'(u_peer.got[3]));
        repeat (8) @(posedge clk);
        bus(0, im_pkg::OFS_PAYLOAD, 0);
        chk("first read byte", 32'h96, rdat);
        while (u_peer.n_sent < 2) @(posedge clk);
        repeat (8) @(posedge clk);
        chk_min("byte gap", 41 * 12.0, u_peer.t_low);
        bus(1, im_pkg::OFS_CONTROL, 32'h2);
        wait_idle();
        bus(0, im_pkg::OFS_PAYLOAD, 0);
        chk("last read byte", 32'hb4, rdat);
        repeat (100) @(posedge clk);
        chk("bytes served", 2, u_peer.n_sent);
        $display("read test done");
        give_verdict();
    end
endmodule : im_i2c_master_test
`default_nettype wire
